// ===== dv/board_partner.sv
// board side model: crystal, pll lock and the shared strap/reference pin
`timescale 1ns/1ps
`default_nettype none
module board_partner #(
    parameter int LOCK_CYCLES = 12
) (
    // bench clock and board levels
    input  wire logic i_clock,
    input  wire logic i_power_good_powerdown_n,
    input  wire logic i_strap,
    // shared pin, block side
    input  wire logic i_ref_out,
    input  wire logic i_ref_oe,
    // to the block
    output logic      o_reference_clock,
    output logic      o_pll_locked,
    output logic      o_pin
);
    int lock_count = 0;

    // free-running crystal, phase unrelated to the bench clock
    initial begin
        o_reference_clock = 1'b0;
        #7;
        forever #100 o_reference_clock = ~o_reference_clock;
    end

    // lock lags power good and is lost in power down
    always @(posedge i_clock) begin
        if (!i_power_good_powerdown_n) begin
            lock_count <= 0;
        end else if (lock_count < LOCK_CYCLES) begin
            lock_count <= lock_count + 1;
        end
    end
    assign o_pll_locked = (lock_count == LOCK_CYCLES);

    // strap level only reaches the pin while the block is not driving it
    assign o_pin = i_ref_oe ? i_ref_out : i_strap;
endmodule
`default_nettype wire

// ===== dv/clock_buffer_chk.sv
// port assertions for the clock buffer power management block
`timescale 1ns/1ps
`default_nettype none
module clock_buffer_chk (
    input wire logic       i_clock,
    input wire logic       i_reset,
    input wire logic       i_reg_write,
    input wire logic       i_reg_read,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       i_power_good_powerdown_n,
    input wire logic [7:0] i_output_enable_n_pins,
    input wire logic       i_pll_locked,
    input wire logic       o_reference_copy_oe,
    input wire logic [1:0] o_spread_select,
    input wire logic [7:0] o_bclk_true,
    input wire logic [7:0] o_bclk_comp,
    input wire logic [6:0] o_smbus_address
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    // five quiet samples cover the pin, the two sync flops, the state and the output flop
    sequence no_lock_quiet;
        (!i_pll_locked && !i_reg_write) [*5];
    endsequence
    sequence power_down_quiet;
        (!i_power_good_powerdown_n && !i_reg_write) [*5];
    endsequence

    a_address_legal: assert property (o_smbus_address inside {7'h68, 7'h6A})
        else $error("bus address outside the two strap values");
    a_spread_legal: assert property (o_spread_select != 2'h3)
        else $error("spread select holds an unused code");
    a_straps_held: assert property (o_reference_copy_oe && $past(o_reference_copy_oe)
        |-> $stable(o_smbus_address) && $stable(o_spread_select))
        else $error("strap results changed after start-up");
    a_ref_hiz_first: assert property ($rose(o_reference_copy_oe)
        |-> $past(i_power_good_powerdown_n, 2))
        else $error("reference pin driven before power good");
    a_ref_oe_kept: assert property (!$fell(o_reference_copy_oe))
        else $error("reference pin released after start-up");
    a_blocked_unlocked: assert property (no_lock_quiet
        |=> $stable(o_bclk_true) && $stable(o_bclk_comp))
        else $error("pairs moved without pll lock");
    a_power_down_still: assert property (power_down_quiet
        |=> $stable(o_bclk_true) && $stable(o_bclk_comp))
        else $error("pairs moved in power down");
    a_read_idle_zero: assert property (!$past(i_reg_read) |-> o_reg_rdata == 8'h00)
        else $error("read data outside the read cycle");
    for (genvar g = 0; g < 8; g++) begin : pair_chk
        a_pin_stops_pair: assert property ((i_output_enable_n_pins[g] && !i_reg_write) [*4]
            |=> $stable(o_bclk_true[g]) && $stable(o_bclk_comp[g]))
            else $error("pair moved with its enable pin high");
    end
endmodule

bind clock_buffer_power_mgmt clock_buffer_chk clock_buffer_chk_inst (
    .i_clock, .i_reset, .i_reg_write, .i_reg_read, .o_reg_rdata, .i_power_good_powerdown_n,
    .i_output_enable_n_pins, .i_pll_locked, .o_reference_copy_oe, .o_spread_select,
    .o_bclk_true, .o_bclk_comp, .o_smbus_address);
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the clock buffer power management block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       i_clock;
    logic       i_reset;
    logic [7:0] i_reg_addr;
    logic [7:0] i_reg_wdata;
    logic       i_reg_write;
    logic       i_reg_read;
    logic [7:0] o_reg_rdata;
    logic       pg;
    logic [7:0] oe_n;
    logic [1:0] pad;
    logic       strap;
    logic       ref_clk;
    logic       locked;
    logic       pin;
    logic       ref_out;
    logic       ref_oe;
    logic [1:0] spread;
    logic [7:0] bt;
    logic [7:0] bc;
    logic [6:0] addr;
    logic       rd_seen;
    logic [7:0] exp_q[$];
    int         n_errors;
    int         checked;

    clock_buffer_power_mgmt clock_buffer_power_mgmt_inst (
        .i_clock, .i_reset, .i_clock_enable(1'b1), .i_reg_addr, .i_reg_wdata, .i_reg_write,
        .i_reg_read, .o_reg_rdata, .i_power_good_powerdown_n(pg), .i_output_enable_n_pins(oe_n),
        .i_spread_strap(pad), .i_reference_clock(ref_clk), .i_address_select_strap(pin),
        .o_reference_copy_out(ref_out), .o_reference_copy_oe(ref_oe), .i_pll_locked(locked),
        .o_spread_select(spread), .o_bclk_true(bt), .o_bclk_comp(bc), .o_smbus_address(addr));
    board_partner board_partner_inst (
        .i_clock, .i_power_good_powerdown_n(pg), .i_strap(strap), .i_ref_out(ref_out),
        .i_ref_oe(ref_oe), .o_reference_clock(ref_clk), .o_pll_locked(locked), .o_pin(pin));

    initial i_clock = 1'b0;
    always #12.5 i_clock = ~i_clock;

    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_clock);
        i_reg_read <= 1'b0;
    endtask
    // sel 0 waits for the reference pin drive, 1 for lock
    task automatic wait_up(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? ref_oe : locked) !== 1'b1) begin
            @(posedge i_clock);
            n++;
            if (n > 300) begin
                n_errors++;
                finish_test();
            end
        end
    endtask
    // three reference periods, so a running output must toggle
    task automatic watch(output logic [7:0] tog, output logic rtog);
        logic [7:0] pt;
        logic       pr;
        tog = 8'h00;
        rtog = 1'b0;
        @(negedge i_clock);
        pt = bt;
        pr = ref_out;
        repeat (24) begin
            @(negedge i_clock);
            tog |= bt ^ pt;
            rtog |= ref_out ^ pr;
            pt = bt;
            pr = ref_out;
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge i_clock) rd_seen <= i_reg_read;
    always @(negedge i_clock) begin
        if (rd_seen && exp_q.size() > 0) begin
            check(o_reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        logic [7:0] tog;
        logic [7:0] m;
        logic [7:0] e;
        logic [7:0] x;
        logic [1:0] f;
        logic       rtog;
        i_reset = 1'b1;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_reg_write = 1'b0;
        i_reg_read = 1'b0;
        pg = 1'b0;
        oe_n = 8'hFF;
        pad = 2'h0;
        strap = 1'b0;
        n_errors = 0;
        checked = 0;
        void'($urandom(32'h9F188483));
        for (int r = 0; r < 4; r++) begin
            i_reset <= 1'b1;
            pg <= 1'b0;
            oe_n <= 8'hFF;
            tick(3);
            i_reset <= 1'b0;
            f = r[1:0];
            tick(1);
            check(8'(ref_oe), 8'h00);
            if (r == 0) begin
                rd(8'h01, 8'hFF);
                rd(8'h03, 8'h10);
                rd(8'h0B, 8'h00);
                rd(8'h20, 8'h00);
                rd(8'h0C, 8'h00);
                wr(8'h0B, 8'hFF);
                rd(8'h0B, 8'h03);
            end
            wr(8'h0B, {6'h00, f});
            strap <= r[0];
            pad <= r[1:0];
            pg <= 1'b1;
            wait_up(0);
            check(8'(addr), r[0] ? 8'h6A : 8'h68);
            check(8'(spread), r[1] ? 8'h02 : (r[0] ? 8'h01 : 8'h00));
            check(bt, {8{f[0]}});
            wait_up(1);
            strap <= ~r[0];
            pad <= ~r[1:0];
            m = 8'($urandom);
            e = (r == 0) ? 8'hFF : 8'($urandom);
            oe_n <= m;
            // bit 4 of byte 3 cleared so REF follows the cleared enable bits
            wr(8'h01, e);
            wr(8'h03, 8'h00);
            tick(8);
            check(8'(addr), r[0] ? 8'h6A : 8'h68);
            check(8'(spread), r[1] ? 8'h02 : (r[0] ? 8'h01 : 8'h00));
            rd(8'h0C, {5'h07, r[1], r[0] & ~r[1], r[0]});
            watch(tog, rtog);
            x = ~m & e;
            check(tog, x);
            check(bt & ~x, {8{f[0]}} & ~x);
            check(bc & ~x, {8{f[1]}} & ~x);
            check(8'(rtog), (e == 8'hFF) ? 8'h01 : 8'h00);
            wr(8'h03, r[1] ? 8'h30 : 8'h10);
            pg <= 1'b0;
            tick(8);
            watch(tog, rtog);
            check(tog, 8'h00);
            check(bt, {8{f[0]}});
            check(bc, {8{f[1]}});
            check(8'(rtog), {7'h00, r[1]});
            tick(1);
            pg <= 1'b1;
            tick(4);
            wait_up(1);
            tick(8);
            watch(tog, rtog);
            check(tog, x);
            tick(1);
        end
        finish_test();
    end
endmodule
`default_nettype wire

// ===== rtl/clock_buffer_pkg.sv
// constants shared by the clock buffer power management design
package clock_buffer_pkg;
    localparam int NUM_OUTPUTS = 8;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 8;

    // register offsets
    localparam logic [7:0] OFFS_OUTPUT_ENABLE = 8'h01;
    localparam logic [7:0] OFFS_REF_CONTROL   = 8'h03;
    localparam logic [7:0] OFFS_STOP_STATE    = 8'h0B;
    localparam logic [7:0] OFFS_STATUS        = 8'h0C;

    // field positions
    localparam int REF_ENABLE_BIT      = 4;
    localparam int REF_RUN_IN_PD_BIT   = 5;
    localparam int STOP_TRUE_BIT       = 0;
    localparam int STOP_COMP_BIT       = 1;
    localparam int STATUS_ADDR_SEL_BIT = 0;
    localparam int STATUS_SPREAD_LSB   = 1;
    localparam int STATUS_STARTED_BIT  = 3;
    localparam int STATUS_LOCKED_BIT   = 4;
    localparam int STATUS_PWRGD_BIT    = 5;

    // reset values
    localparam logic [7:0] RST_OUTPUT_ENABLE = 8'hFF;
    localparam logic [7:0] RST_REF_CONTROL   = 8'h10;
    localparam logic [7:0] RST_STOP_STATE    = 8'h00;

    // bus addresses chosen by the strap
    localparam logic [6:0] SMBUS_ADDR_STRAP0 = 7'h68;
    localparam logic [6:0] SMBUS_ADDR_STRAP1 = 7'h6A;

    // spread selections, also the pad code of the three-level strap
    localparam logic [1:0] SPREAD_OFF     = 2'h0;
    localparam logic [1:0] SPREAD_QUARTER = 2'h1;
    localparam logic [1:0] SPREAD_HALF    = 2'h2;

    typedef enum logic [1:0] {
        ST_WAIT_POWER_GOOD,
        ST_WAIT_LOCK,
        ST_RUN,
        ST_POWER_DOWN
    } power_state_t;
endpackage

// ===== rtl/clock_buffer_power_mgmt.sv
// power-good sequencing, strap capture and output gating of the clock buffer
`timescale 1ns/1ps
`default_nettype none
module clock_buffer_power_mgmt (
    // clock and control
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    input  wire logic       i_clock_enable,
    // register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_write,
    input  wire logic       i_reg_read,
    output logic      [7:0] o_reg_rdata,
    // board pins
    input  wire logic       i_power_good_powerdown_n,
    input  wire logic [7:0] i_output_enable_n_pins,
    input  wire logic [1:0] i_spread_strap,
    input  wire logic       i_reference_clock,
    // shared address strap / reference copy pin
    input  wire logic       i_address_select_strap,
    output logic            o_reference_copy_out,
    output logic            o_reference_copy_oe,
    // analog core
    input  wire logic       i_pll_locked,
    output logic      [1:0] o_spread_select,
    // differential outputs
    output logic      [7:0] o_bclk_true,
    output logic      [7:0] o_bclk_comp,
    // strap results
    output logic      [6:0] o_smbus_address
);
    // synchronised pins
    logic       power_good;
    logic [7:0] enable_n;
    logic [1:0] spread_pin;
    logic       ref_level;
    logic       addr_pin;
    logic       locked;

    pin_sync #(.WIDTH(1)) u_sync_pg (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_async        (i_power_good_powerdown_n),
        .o_sync         (power_good)
    );

    pin_sync #(.WIDTH(8)) u_sync_oe (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_async        (i_output_enable_n_pins),
        .o_sync         (enable_n)
    );

    pin_sync #(.WIDTH(2)) u_sync_spread (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_async        (i_spread_strap),
        .o_sync         (spread_pin)
    );

    // the reference is only level-sampled, so pairs toggle at its rate
    pin_sync #(.WIDTH(1)) u_sync_ref (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_async        (i_reference_clock),
        .o_sync         (ref_level)
    );

    // shared pin read back; it carries the strap only while undriven
    pin_sync #(.WIDTH(1)) u_sync_addr (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_async        (i_address_select_strap),
        .o_sync         (addr_pin)
    );

    // lock from the analog core is treated as asynchronous
    pin_sync #(.WIDTH(1)) u_sync_lock (
        .i_clock        (i_clock),
        .i_reset        (i_reset),
        .i_clock_enable (i_clock_enable),
        .i_async        (i_pll_locked),
        .o_sync         (locked)
    );

    // configuration bytes
    logic [7:0] output_enable_bits;
    logic [7:0] ref_control;
    logic [7:0] stop_state_field;
    logic [7:0] status;

    config_bytes u_config (
        .i_clock         (i_clock),
        .i_reset         (i_reset),
        .i_clock_enable  (i_clock_enable),
        .i_reg_addr      (i_reg_addr),
        .i_reg_wdata     (i_reg_wdata),
        .i_reg_write     (i_reg_write),
        .i_reg_read      (i_reg_read),
        .o_reg_rdata     (o_reg_rdata),
        .i_status        (status),
        .o_output_enable (output_enable_bits),
        .o_ref_control   (ref_control),
        .o_stop_state    (stop_state_field)
    );

    // sequencing state
    clock_buffer_pkg::power_state_t state;
    clock_buffer_pkg::power_state_t next_state;
    logic       addr_strap;
    logic       next_addr_strap;
    logic [1:0] next_spread_select;
    logic [6:0] next_smbus_address;
    logic       started;
    logic       next_started;
    logic       capture;

    logic ref_run_in_powerdown_bit;
    logic ref_enable_bit;
    logic stop_true;
    logic stop_comp;

    assign ref_run_in_powerdown_bit = ref_control[clock_buffer_pkg::REF_RUN_IN_PD_BIT];
    assign ref_enable_bit           = ref_control[clock_buffer_pkg::REF_ENABLE_BIT];
    assign stop_true                = stop_state_field[clock_buffer_pkg::STOP_TRUE_BIT];
    assign stop_comp                = stop_state_field[clock_buffer_pkg::STOP_COMP_BIT];

    // straps are caught once, on the first power-good high
    assign capture = (state == clock_buffer_pkg::ST_WAIT_POWER_GOOD) && power_good;

    always_comb begin
        next_addr_strap    = addr_strap;
        next_spread_select = o_spread_select;
        next_smbus_address = o_smbus_address;
        if (i_clock_enable && capture) begin
            next_addr_strap    = addr_pin;
            next_smbus_address = addr_pin ? clock_buffer_pkg::SMBUS_ADDR_STRAP1
                                          : clock_buffer_pkg::SMBUS_ADDR_STRAP0;
            // the three-level pad reads as 1x high, 01 mid, 00 low
            if (spread_pin[1]) begin
                next_spread_select = clock_buffer_pkg::SPREAD_HALF;
            end else if (spread_pin[0]) begin
                next_spread_select = clock_buffer_pkg::SPREAD_QUARTER;
            end else begin
                next_spread_select = clock_buffer_pkg::SPREAD_OFF;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            addr_strap      <= 1'b0;
            o_spread_select <= clock_buffer_pkg::SPREAD_OFF;
            o_smbus_address <= clock_buffer_pkg::SMBUS_ADDR_STRAP0;
        end else begin
            addr_strap      <= next_addr_strap;
            o_spread_select <= next_spread_select;
            o_smbus_address <= next_smbus_address;
        end
    end

    always_comb begin
        next_state   = state;
        next_started = started;
        unique case (state)
            clock_buffer_pkg::ST_WAIT_POWER_GOOD: begin
                if (capture) begin
                    next_started = 1'b1;
                    next_state   = clock_buffer_pkg::ST_WAIT_LOCK;
                end
            end
            clock_buffer_pkg::ST_WAIT_LOCK: begin
                if (!power_good) begin
                    next_state = clock_buffer_pkg::ST_POWER_DOWN;
                end else if (locked) begin
                    next_state = clock_buffer_pkg::ST_RUN;
                end
            end
            clock_buffer_pkg::ST_RUN: begin
                if (!power_good) begin
                    next_state = clock_buffer_pkg::ST_POWER_DOWN;
                end else if (!locked) begin
                    next_state = clock_buffer_pkg::ST_WAIT_LOCK;
                end
            end
            clock_buffer_pkg::ST_POWER_DOWN: begin
                // straps stay as caught; leaving power-down waits for lock again
                if (power_good) begin
                    next_state = clock_buffer_pkg::ST_WAIT_LOCK;
                end
            end
        endcase
        if (!i_clock_enable) begin
            next_state   = state;
            next_started = started;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state   <= clock_buffer_pkg::ST_WAIT_POWER_GOOD;
            started <= 1'b0;
        end else begin
            state   <= next_state;
            started <= next_started;
        end
    end

    // output gating
    logic       running;
    logic [7:0] pair_run;
    logic       ref_gate_open;
    logic [7:0] next_bclk_true;
    logic [7:0] next_bclk_comp;
    logic       next_ref_out;
    logic       next_ref_oe;

    // pairs leave reset parked at the default stop levels
    localparam logic [7:0] RESET_PARK_TRUE =
        {8{clock_buffer_pkg::RST_STOP_STATE[clock_buffer_pkg::STOP_TRUE_BIT]}};
    localparam logic [7:0] RESET_PARK_COMP =
        {8{clock_buffer_pkg::RST_STOP_STATE[clock_buffer_pkg::STOP_COMP_BIT]}};

    assign running = (state == clock_buffer_pkg::ST_RUN);
    // any cleared enable bit hands REF to its own enable bit
    assign ref_gate_open = (&output_enable_bits) || ref_enable_bit;

    genvar ch;
    generate
        for (ch = 0; ch < clock_buffer_pkg::NUM_OUTPUTS; ch++) begin : g_out
            // the running state and only this channel's pin and bit decide its pair
            assign pair_run[ch] = running && output_enable_bits[ch] && !enable_n[ch];
            always_comb begin
                if (pair_run[ch]) begin
                    next_bclk_true[ch] = ref_level;
                    next_bclk_comp[ch] = !ref_level;
                end else begin
                    // power-down, no lock, pin high or bit cleared all park the pair
                    next_bclk_true[ch] = stop_true;
                    next_bclk_comp[ch] = stop_comp;
                end
                if (!i_clock_enable) begin
                    next_bclk_true[ch] = o_bclk_true[ch];
                    next_bclk_comp[ch] = o_bclk_comp[ch];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_bclk_true <= RESET_PARK_TRUE;
            o_bclk_comp <= RESET_PARK_COMP;
        end else begin
            o_bclk_true <= next_bclk_true;
            o_bclk_comp <= next_bclk_comp;
        end
    end

    // a disabled REF is driven low; only the first start-up leaves it floating
    always_comb begin
        next_ref_out = 1'b0;
        next_ref_oe  = 1'b0;
        if (!started) begin
            next_ref_oe = 1'b0;
        end else if (!power_good) begin
            next_ref_oe  = 1'b1;
            next_ref_out = ref_run_in_powerdown_bit & ref_level;
        end else begin
            next_ref_oe = 1'b1;
            if (ref_gate_open) begin
                next_ref_out = ref_level;
            end
        end
        if (!i_clock_enable) begin
            next_ref_out = o_reference_copy_out;
            next_ref_oe  = o_reference_copy_oe;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reference_copy_out <= 1'b0;
            o_reference_copy_oe  <= 1'b0;
        end else begin
            o_reference_copy_out <= next_ref_out;
            o_reference_copy_oe  <= next_ref_oe;
        end
    end

    always_comb begin
        status                                         = 8'h00;
        status[clock_buffer_pkg::STATUS_ADDR_SEL_BIT]  = addr_strap;
        status[clock_buffer_pkg::STATUS_SPREAD_LSB+:2] = o_spread_select;
        status[clock_buffer_pkg::STATUS_STARTED_BIT]   = started;
        status[clock_buffer_pkg::STATUS_LOCKED_BIT]    = running;
        status[clock_buffer_pkg::STATUS_PWRGD_BIT]     = power_good;
    end
endmodule
`default_nettype wire

// ===== rtl/config_bytes.sv
// configuration byte file behind the plain register port
`timescale 1ns/1ps
`default_nettype none
module config_bytes (
    // clock and control
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    input  wire logic       i_clock_enable,
    // register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_write,
    input  wire logic       i_reg_read,
    output logic      [7:0] o_reg_rdata,
    // status from the control logic
    input  wire logic [7:0] i_status,
    // configuration
    output logic      [7:0] o_output_enable,
    output logic      [7:0] o_ref_control,
    output logic      [7:0] o_stop_state
);
    logic [7:0] next_output_enable;
    logic [7:0] next_ref_control;
    logic [7:0] next_stop_state;
    logic [7:0] next_rdata;

    always_comb begin
        next_output_enable = o_output_enable;
        next_ref_control   = o_ref_control;
        next_stop_state    = o_stop_state;
        next_rdata         = 8'h00;
        if (i_clock_enable && i_reg_write) begin
            unique case (i_reg_addr)
                clock_buffer_pkg::OFFS_OUTPUT_ENABLE: next_output_enable = i_reg_wdata;
                clock_buffer_pkg::OFFS_REF_CONTROL:   next_ref_control   = i_reg_wdata;
                clock_buffer_pkg::OFFS_STOP_STATE:    next_stop_state    = {6'h00, i_reg_wdata[1:0]};
                default:                              next_rdata         = 8'h00;
            endcase
        end
        // read data stand for exactly one cycle; unmapped bytes read zero
        if (i_clock_enable && i_reg_read) begin
            unique case (i_reg_addr)
                clock_buffer_pkg::OFFS_OUTPUT_ENABLE: next_rdata = o_output_enable;
                clock_buffer_pkg::OFFS_REF_CONTROL:   next_rdata = o_ref_control;
                clock_buffer_pkg::OFFS_STOP_STATE:    next_rdata = o_stop_state;
                clock_buffer_pkg::OFFS_STATUS:        next_rdata = i_status;
                default:                              next_rdata = 8'h00;
            endcase
        end else if (!i_clock_enable) begin
            next_rdata = o_reg_rdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_output_enable <= clock_buffer_pkg::RST_OUTPUT_ENABLE;
            o_ref_control   <= clock_buffer_pkg::RST_REF_CONTROL;
            o_stop_state    <= clock_buffer_pkg::RST_STOP_STATE;
            o_reg_rdata     <= 8'h00;
        end else begin
            o_output_enable <= next_output_enable;
            o_ref_control   <= next_ref_control;
            o_stop_state    <= next_stop_state;
            o_reg_rdata     <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pin_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and control
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    input  wire logic             i_clock_enable,
    // pins
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] first_stage;
    logic [WIDTH-1:0] next_first_stage;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_first_stage = first_stage;
        next_sync        = o_sync;
        if (i_clock_enable) begin
            next_first_stage = i_async;
            next_sync        = first_stage;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            first_stage <= '0;
            o_sync      <= '0;
        end else begin
            first_stage <= next_first_stage;
            o_sync      <= next_sync;
        end
    end
endmodule
`default_nettype wire
